/* File: dv/bio_board.sv */
// Purpose: board circuitry on one bank of port pins
// Assumes: the board drives only pins that the device has released
// Notes:   wire level worked out from the device value, the device enable and the board value
`timescale 1ns/1ps
module bio_board #(
  parameter int W = 8
) (
  // device side
  input  wire logic [W-1:0] dev_i,
  input  wire logic [W-1:0] dev_oe_i,
  // board side
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] level_o
);
  // never fights a pin the device drives
  assign level_o = (dev_oe_i & dev_i) | (~dev_oe_i & ext_i);
endmodule

/* File: dv/test_bidirectional_io_ports.sv */
// Purpose: self-checking bench for the i/o port block
// Assumes: inputs change at the falling edge, seed fixed
// Notes:   expectations come from the pin equation below, not the design
`timescale 1ns/1ps
module test_bidirectional_io_ports;
  import bio_pkg::*;
  logic       mclk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       en = 1'b0, rd = 1'b0, wr = 1'b0, bop = 1'b0, bset = 1'b0, dl = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [2:0] sel = 3'h0, bs;
  logic [7:0] wd = 8'h00, wk = 8'h00, d, x, m, e, rdat, bo, boe, co, coe, pb, pc;
  logic [7:0] ext_b = 8'h00, ext_c = 8'h00;
  logic [7:0] rdat_gp, co_gp, coe_gp;
  logic [3:0] ext_a = 4'h0, pa, ao, aoe;
  logic       s;
  bio_sel_t   dsel = BIO_SEL_NONE;
  int         err_total = 0, tests_run = 0, seed = 40;
  ////////////////////////////////////////////////////////////////////////////////
  bio_ports i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cycle_en_i(en),
    .file_addr_i(addr), .file_rd_i(rd), .file_wr_i(wr), .file_wdata_i(wd),
    .bit_op_i(bop), .bit_set_i(bset), .bit_sel_i(sel), .file_rdata_o(rdat),
    .dir_load_i(dl), .dir_sel_i(dsel), .work_reg_i(wk),
    .port_a_bit_i(pa), .port_a_bit_o(ao), .port_a_bit_oe_o(aoe),
    .port_b_bit_i(pb), .port_b_bit_o(bo), .port_b_bit_oe_o(boe),
    .port_c_bit_i(pc), .port_c_bit_o(co), .port_c_bit_oe_o(coe));
  // storage variant: 07h is a plain register with no pins
  bio_ports #(.HAS_PORT_C(1'b0)) i_dut_gp (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .cycle_en_i(en), .file_addr_i(addr), .file_rd_i(rd), .file_wr_i(wr), .file_wdata_i(wd),
    .bit_op_i(bop), .bit_set_i(bset), .bit_sel_i(sel), .file_rdata_o(rdat_gp),
    .dir_load_i(dl), .dir_sel_i(dsel), .work_reg_i(wk),
    .port_a_bit_i(pa), .port_a_bit_o(), .port_a_bit_oe_o(),
    .port_b_bit_i(pb), .port_b_bit_o(), .port_b_bit_oe_o(),
    .port_c_bit_i(pc), .port_c_bit_o(co_gp), .port_c_bit_oe_o(coe_gp));
  bio_board #(.W(4)) i_brd_a (.dev_i(ao), .dev_oe_i(aoe), .ext_i(ext_a), .level_o(pa));
  bio_board #(.W(8)) i_brd_b (.dev_i(bo), .dev_oe_i(boe), .ext_i(ext_b), .level_o(pb));
  bio_board #(.W(8)) i_brd_c (.dev_i(co), .dev_oe_i(coe), .ext_i(ext_c), .level_o(pc));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] pin(input logic [7:0] o, oe, ext);
    return (oe & o) | (~oe & ext);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one file access, then room for read data and pins to settle
  task automatic op(input logic [4:0] a, input int r, w, b, st,
                    input logic [2:0] bi, input logic [7:0] v);
    @(negedge mclk_i);
    {en, rd, wr, bop, bset, sel, wd, addr} = {1'b1, r[0], w[0], b[0], st[0], bi, v, a};
    @(negedge mclk_i);
    {en, rd, wr, bop} = 4'h0;
    repeat (3) @(negedge mclk_i);
  endtask
  task automatic dload(input bio_sel_t t, input logic [7:0] v);
    @(negedge mclk_i);
    {en, dl, wk} = {2'b11, v};
    dsel = t;
    @(negedge mclk_i);
    {en, dl} = 2'b00;
    dsel = BIO_SEL_NONE;
    repeat (3) @(negedge mclk_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk({4'h0, aoe}, 8'h00);
    chk(boe, 8'h00);
    chk(coe | coe_gp, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      x = 8'($random(seed));
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      {ext_b, ext_c, ext_a} = {x, ~x, x[3:0]};
      dload(BIO_SEL_B, m);
      dload(BIO_SEL_C, ~m);
      dload(BIO_SEL_A, m);
      chk(boe, ~m);
      chk({aoe, coe[3:0]}, {~m[3:0], m[3:0]});
      chk(coe, m);
      op(5'h06, 0, 1, 0, 0, 3'h0, d);
      op(5'h07, 0, 1, 0, 0, 3'h0, ~d);
      op(5'h05, 0, 1, 0, 0, 3'h0, {~d[7:4], d[3:0]});
      chk(pb, pin(d, ~m, x));
      op(5'h06, 1, 0, 0, 0, 3'h0, 8'h00);
      chk(rdat, pin(d, ~m, x));
      op(5'h07, 1, 0, 0, 0, 3'h0, 8'h00);
      chk(rdat, pin(~d, m, ~x));
      chk(rdat_gp, ~d);
      chk(co_gp | coe_gp, 8'h00);
      op(5'h05, 1, 0, 0, 0, 3'h0, 8'h00);
      chk(rdat, pin({4'h0, d[3:0]}, {4'h0, ~m[3:0]}, {4'h0, x[3:0]}));
      s = i[0];
      bs = 3'($random(seed));
      e = pin(d, ~m, x);
      e[bs] = s;
      op(5'h06, 0, 0, 1, s, bs, 8'h00);
      chk(bo, e);
      ext_b = ~x;
      // pins pass two sync flops before a read can see them
      repeat (2) @(negedge mclk_i);
      op(5'h06, 1, 0, 0, 0, 3'h0, 8'h00);
      chk(rdat, pin(e, ~m, ~x));
      $display("port test %0d done", i);
    end
    op(5'h08, 1, 0, 0, 0, 3'h0, 8'h00);
    chk(rdat, 8'h00);
    @(negedge mclk_i);
    reset_n_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk(bo, e);
    chk({4'h0, ao}, {4'h0, d[3:0]});
    chk(co, ~d);
    chk(boe, 8'h00);
    chk({4'h0, aoe} | coe, 8'h00);
    $display("second reset test done");
    report_and_stop();
  end
endmodule

/* File: shared/bio_defines.svh */
// Purpose: constants for the bidirectional i/o port block
// Assumes: 8-bit file bus from the core, one access per instruction-cycle enable
// Notes:   offsets are file addresses
// Function
// RULE1: port reads return pin levels, not latches
// RULE2: every reset sets all direction bits high
// RULE3: port a has four pins, bits 7-4 zero
// RULE4: port b is a full eight-bit port
// RULE5: address 07h is port c or storage
// RULE6: direction loaded from working register by instruction
// RULE7: direction one floats pin, zero drives latch
// RULE8: direction registers cannot be read back
// RULE9: inputs unlatched; output latches hold until written
// RULE10: every pin has its own direction bit
// RULE11: bit operations read pins, write whole port
// RULE12: read-modify-write copies input pin level into latch
// RULE13: output latches unchanged by any reset
// RULE14: outside circuitry must not fight driven pins
// RULE15: writes land cycle end, reads sample start
// RULE16: writes to port a upper bits ignored
`ifndef BIO_DEFINES_SVH
`define BIO_DEFINES_SVH
`define BIO_ADDR_PORT_A   5'h05
`define BIO_ADDR_PORT_B   5'h06
`define BIO_ADDR_PORT_C   5'h07
`define BIO_DIR_RESET     8'hFF
`define BIO_PORT_A_MASK   8'h0F
`define BIO_PORT_A_WIDTH  4
`define BIO_PORT_WIDTH    8
`endif

/* File: shared/bio_pkg.sv */
// Purpose: types for the bidirectional i/o port block
// Assumes: nothing
// Notes:   port select used for direction loads
package bio_pkg;
  typedef enum logic [1:0] {
    BIO_SEL_A,
    BIO_SEL_B,
    BIO_SEL_C,
    BIO_SEL_NONE
  } bio_sel_t;
endpackage

/* File: verilog/bio_pin_sync.sv */
// Purpose: two-flop synchroniser for a bank of pins
// Assumes: pins are asynchronous to mclk_i
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module bio_pin_sync #(
  parameter int W = 8
) (
  // clock
  input  wire logic         mclk_i,
  // pins
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = async_i;
    next_sync   = stage1;
  end

  always_ff @(posedge mclk_i) begin
    stage1 <= next_stage1;
    sync_o <= next_sync;
  end
endmodule

/* File: verilog/bio_ports.sv */
// Purpose: three bidirectional general-purpose i/o ports behind the file bus
// Assumes: core presents an access in a cycle with cycle_en_i high
// Notes:   read data is registered; bit operations are done inside this block
`timescale 1ns/1ps
`include "bio_defines.svh"
module bio_ports #(
  parameter bit HAS_PORT_C = 1'b1
) (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                reset_n_i,
  input  wire logic                cycle_en_i,
  // file access from the core
  input  wire logic [4:0]          file_addr_i,
  input  wire logic                file_rd_i,
  input  wire logic                file_wr_i,
  input  wire logic [7:0]          file_wdata_i,
  input  wire logic                bit_op_i,
  input  wire logic                bit_set_i,
  input  wire logic [2:0]          bit_sel_i,
  output logic      [7:0]          file_rdata_o,
  // direction load instruction
  input  wire logic                dir_load_i,
  input  wire bio_pkg::bio_sel_t   dir_sel_i,
  input  wire logic [7:0]          work_reg_i,
  // port a pins
  input  wire logic [3:0]          port_a_bit_i,
  output logic      [3:0]          port_a_bit_o,
  output logic      [3:0]          port_a_bit_oe_o,
  // port b pins
  input  wire logic [7:0]          port_b_bit_i,
  output logic      [7:0]          port_b_bit_o,
  output logic      [7:0]          port_b_bit_oe_o,
  // port c pins
  input  wire logic [7:0]          port_c_bit_i,
  output logic      [7:0]          port_c_bit_o,
  output logic      [7:0]          port_c_bit_oe_o
);
  import bio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_a;
  logic [7:0] pin_b;
  logic [7:0] pin_c;

  bio_pin_sync #(.W(4)) u_sync_a (
    .mclk_i  (mclk_i),
    .async_i (port_a_bit_i),
    .sync_o  (pin_a)
  );
  bio_pin_sync #(.W(8)) u_sync_b (
    .mclk_i  (mclk_i),
    .async_i (port_b_bit_i),
    .sync_o  (pin_b)
  );
  bio_pin_sync #(.W(8)) u_sync_c (
    .mclk_i  (mclk_i),
    .async_i (port_c_bit_i),
    .sync_o  (pin_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin sample taken at the start of the instruction cycle
  logic [7:0] pin_view;
  logic [7:0] rmw_base;
  logic [7:0] wr_value;
  logic [7:0] gp_store;
  logic       hit_a;
  logic       hit_b;
  logic       hit_c;

  always_comb begin
    hit_a    = (file_addr_i == `BIO_ADDR_PORT_A);
    hit_b    = (file_addr_i == `BIO_ADDR_PORT_B);
    hit_c    = (file_addr_i == `BIO_ADDR_PORT_C);
    pin_view = 8'h00;
    if (hit_a) begin
      pin_view = {4'h0, pin_a};                     // see RULE1 see RULE3
    end else if (hit_b) begin
      pin_view = pin_b;                             // see RULE1 see RULE4
    end else if (hit_c) begin
      pin_view = HAS_PORT_C ? pin_c : gp_store;     // see RULE5
    end
    rmw_base = pin_view;                            // see RULE11 see RULE12
    wr_value = file_wdata_i;
    if (bit_op_i) begin
      wr_value = rmw_base;
      wr_value[bit_sel_i] = bit_set_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latches, storage and direction registers
  logic [3:0] latch_a;
  logic [7:0] latch_b;
  logic [7:0] latch_c;
  logic [3:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] dir_c;
  logic [7:0] rdata;
  logic [3:0] next_latch_a;
  logic [7:0] next_latch_b;
  logic [7:0] next_latch_c;
  logic [7:0] next_gp_store;
  logic [3:0] next_dir_a;
  logic [7:0] next_dir_b;
  logic [7:0] next_dir_c;
  logic [7:0] next_rdata;
  logic       wr_go;

  always_comb begin
    wr_go         = cycle_en_i & (file_wr_i | bit_op_i);
    next_latch_a  = latch_a;                        // see RULE9 see RULE13
    next_latch_b  = latch_b;
    next_latch_c  = latch_c;
    next_gp_store = gp_store;
    next_dir_a    = dir_a;
    next_dir_b    = dir_b;
    next_dir_c    = dir_c;
    next_rdata    = rdata;
    if (wr_go && hit_a) begin
      next_latch_a = wr_value[3:0];                 // see RULE16 see RULE15
    end
    if (wr_go && hit_b) begin
      next_latch_b = wr_value;                      // see RULE11
    end
    if (wr_go && hit_c) begin
      if (HAS_PORT_C) begin
        next_latch_c = wr_value;
      end else begin
        next_gp_store = wr_value;                   // see RULE5
      end
    end
    if (cycle_en_i && dir_load_i) begin
      case (dir_sel_i)                              // see RULE6 see RULE10
        BIO_SEL_A: next_dir_a = work_reg_i[3:0];
        BIO_SEL_B: next_dir_b = work_reg_i;
        BIO_SEL_C: next_dir_c = work_reg_i;
        default:   next_dir_a = dir_a;
      endcase
    end
    // direction registers never reach the read path
    if (cycle_en_i && file_rd_i) begin
      next_rdata = pin_view;                        // see RULE8 see RULE15
    end
    if (!reset_n_i) begin
      next_dir_a = 4'(`BIO_DIR_RESET);              // see RULE2
      next_dir_b = `BIO_DIR_RESET;
      next_dir_c = `BIO_DIR_RESET;
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    latch_a  <= next_latch_a;
    latch_b  <= next_latch_b;
    latch_c  <= next_latch_c;
    gp_store <= next_gp_store;
    dir_a    <= next_dir_a;
    dir_b    <= next_dir_b;
    dir_c    <= next_dir_c;
    rdata    <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pin drivers
  logic [3:0] next_a_o;
  logic [3:0] next_a_oe;
  logic [7:0] next_b_o;
  logic [7:0] next_b_oe;
  logic [7:0] next_c_o;
  logic [7:0] next_c_oe;

  always_comb begin
    next_a_o  = next_latch_a;
    next_b_o  = next_latch_b;
    next_c_o  = HAS_PORT_C ? next_latch_c : 8'h00;
    next_a_oe = ~next_dir_a;                        // see RULE7 see RULE14
    next_b_oe = ~next_dir_b;
    next_c_oe = HAS_PORT_C ? ~next_dir_c : 8'h00;
  end

  always_ff @(posedge mclk_i) begin
    port_a_bit_o    <= next_a_o;
    port_a_bit_oe_o <= next_a_oe;
    port_b_bit_o    <= next_b_o;
    port_b_bit_oe_o <= next_b_oe;
    port_c_bit_o    <= next_c_o;
    port_c_bit_oe_o <= next_c_oe;
    file_rdata_o    <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // reset: directions forced high, latches untouched
  a_reset_floats: assert property (@(posedge mclk_i)            // see RULE2
    !reset_n_i |=> (port_a_bit_oe_o == 4'h0) && (port_b_bit_oe_o == 8'h00)
      && (port_c_bit_oe_o == 8'h00))
    else $error("pins driven after reset");

  a_reset_dirs: assert property (@(posedge mclk_i)              // see RULE2
    !reset_n_i |=> (dir_b == `BIO_DIR_RESET) && (dir_c == `BIO_DIR_RESET)
      && (dir_a == 4'hF))
    else $error("direction not all ones after reset");

  a_reset_keeps: assert property (@(posedge mclk_i)              // see RULE13
    !reset_n_i |=> (latch_b === $past(latch_b)) && (latch_a === $past(latch_a))
      && (latch_c === $past(latch_c)))
    else $error("latch changed by reset");

  // read path: pins as seen at the take, on the output two edges later
  a_upper_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE3
    (cycle_en_i && file_rd_i && hit_a) |=> ##1 (file_rdata_o[7:4] == 4'h0))
    else $error("port a upper bits not zero");

  a_read_pins: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE1
    (cycle_en_i && file_rd_i && hit_b) |=> ##1 (file_rdata_o == $past(pin_b, 2)))
    else $error("port b read not pin level");

  a_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE1
    (cycle_en_i && file_rd_i && hit_a) |=> ##1 (file_rdata_o == {4'h0, $past(pin_a, 2)}))
    else $error("port a read not pin level");

  a_read_c: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE5
    (HAS_PORT_C && cycle_en_i && file_rd_i && hit_c) |=> ##1
      (file_rdata_o == $past(pin_c, 2)))
    else $error("port c read not pin level");

  a_read_store: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE5
    (!HAS_PORT_C && cycle_en_i && file_rd_i && hit_c) |=> ##1
      (file_rdata_o == $past(gp_store, 2)))
    else $error("storage read wrong");

  a_read_none: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE8
    (cycle_en_i && file_rd_i && !hit_a && !hit_b && !hit_c) |=> ##1
      (file_rdata_o == 8'h00))
    else $error("unmapped read not zero");

  // direction registers move only on a load or a reset
  a_dir_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE6
    (cycle_en_i && dir_load_i && dir_sel_i == BIO_SEL_B) |=>
      (port_b_bit_oe_o == ~$past(work_reg_i)))
    else $error("direction load missed");

  a_dir_load_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE10
    (cycle_en_i && dir_load_i && dir_sel_i == BIO_SEL_A) |=>
      (port_a_bit_oe_o == ~$past(work_reg_i[3:0])))
    else $error("port a direction load missed");

  a_dir_load_c: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE6
    (HAS_PORT_C && cycle_en_i && dir_load_i && dir_sel_i == BIO_SEL_C) |=>
      (port_c_bit_oe_o == ~$past(work_reg_i)))
    else $error("port c direction load missed");

  a_dir_steady: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE6
    !(cycle_en_i && dir_load_i) |=> (dir_a == $past(dir_a)) && (dir_b == $past(dir_b))
      && (dir_c == $past(dir_c)))
    else $error("direction changed without load");

  // output latches and storage
  a_latch_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE9
    !(cycle_en_i && (file_wr_i || bit_op_i) && hit_b) |=> (latch_b === $past(latch_b)))
    else $error("port b latch changed without write");

  a_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE9
    !(cycle_en_i && (file_wr_i || bit_op_i) && hit_a) |=> (latch_a === $past(latch_a)))
    else $error("port a latch changed without write");

  a_hold_c: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE9
    !(cycle_en_i && (file_wr_i || bit_op_i) && hit_c) |=>
      (latch_c === $past(latch_c)) && (gp_store === $past(gp_store)))
    else $error("port c latch changed without write");

  a_rmw_copy: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE12
    (cycle_en_i && bit_op_i && hit_b) |=>
      (latch_b == (($past(pin_b) & ~(8'h01 << $past(bit_sel_i)))
                  | ({7'h00, $past(bit_set_i)} << $past(bit_sel_i)))))
    else $error("bit operation result wrong");

  a_write_b: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE15
    (cycle_en_i && file_wr_i && !bit_op_i && hit_b) |=>
      (latch_b == $past(file_wdata_i)) && (port_b_bit_o == $past(file_wdata_i)))
    else $error("port b write not landed");

  a_write_c: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE5
    (HAS_PORT_C && cycle_en_i && file_wr_i && !bit_op_i && hit_c) |=>
      (latch_c == $past(file_wdata_i)))
    else $error("port c write not landed");

  a_write_store: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE5
    (!HAS_PORT_C && cycle_en_i && file_wr_i && !bit_op_i && hit_c) |=>
      (gp_store == $past(file_wdata_i)))
    else $error("storage write not landed");

  a_upper_ignored: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE16
    (cycle_en_i && file_wr_i && !bit_op_i && hit_a) |=> (latch_a == $past(file_wdata_i[3:0])))
    else $error("port a write wrong");

  // pin drivers follow latch and direction
  a_drive_latch: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE7
    1'b1 |=> (port_b_bit_o === $past(next_latch_b))
      && (port_b_bit_oe_o == ~$past(next_dir_b)))
    else $error("pin driver mismatch");

  a_drive_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE7
    (port_a_bit_o === latch_a) && (port_a_bit_oe_o == ~dir_a))
    else $error("port a driver mismatch");

  a_drive_c: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE7
    HAS_PORT_C |-> (port_c_bit_o === latch_c) && (port_c_bit_oe_o == ~dir_c))
    else $error("port c driver mismatch");

  a_c_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RULE5
    !HAS_PORT_C |-> (port_c_bit_o == 8'h00) && (port_c_bit_oe_o == 8'h00))
    else $error("storage variant drives port c");
endmodule
